// ---- core/pes_enable_fsm.v ----
// top power state controller with enable modes and sleep entry

`timescale 1ns/1ns
`default_nettype none
`include "pes_defines.vh"
module pes_enable_fsm #(
    parameter NUM_OUT = 6,
    parameter [0:0] PIN_MODE = 1'b1,
    parameter [0:0] HOLD_INPUT_EN = 1'b0,
    parameter [0:0] SLEEP_COMBINE = 1'b0,
    parameter [0:0] SLEEP_REQ_DEFAULT = 1'b0,
    parameter [0:0] SLEEP_ALLOW_DEFAULT = 1'b0,
    parameter [0:0] DEEP_EN_DEFAULT = 1'b0,
    parameter [2:0] THR_DEFAULT = 3'h0,
    parameter [2*NUM_OUT-1:0] SLEEP_SET_DEFAULT = {NUM_OUT{`PES_SET_OFF}},
    parameter [NUM_OUT-1:0] DEEP_ALT_DEFAULT = {NUM_OUT{1'b0}}
) (
    // clock and reset
    input wire ref_clk,
    input wire rst_n,
    // pins from the processor
    input wire power_enable_pin,
    input wire control_input_one,
    input wire control_input_two,
    input wire hold_input,
    // supply monitor comparator results
    input wire supply_above_threshold,
    input wire supply_low_limit,
    input wire supply_high_limit,
    // regulator feedback
    input wire output_fault,
    input wire regs_started,
    // register port
    input wire reg_wr,
    input wire [7:0] reg_addr,
    input wire [7:0] reg_wdata,
    output reg [7:0] reg_rdata,
    // state and output controls
    output reg [NUM_OUT-1:0] out_enable,
    output reg [NUM_OUT-1:0] out_use_alt,
    output reg reset_out_n,
    output wire [6:0] threshold_tenths,
    output wire [5:0] state_onehot
);

    // one-hot state codes, also what the state readback shows
    localparam [5:0] ST_RESET = 6'h01;
    localparam [5:0] ST_SEQ = 6'h02;
    localparam [5:0] ST_ON = 6'h04;
    localparam [5:0] ST_SLEEP = 6'h08;
    localparam [5:0] ST_DEEP = 6'h10;
    localparam [5:0] ST_OFF = 6'h20;

    // synchronised copies of the asynchronous inputs
    wire en_s;
    wire c1_s;
    wire c2_s;
    wire hold_s;
    wire thr_s;
    wire uv_s;
    wire ov_s;
    // state, configuration and edge history
    reg [5:0] state_q;
    reg [5:0] state_d;
    reg [7:0] mon_cfg_q;
    reg slp_allow_q;
    reg slp_req_q;
    reg slp_req_prev_q;
    reg slp_req_edge_q;
    reg deep_en_q;
    reg en_prev_q;
    reg [3:0] restart_q;
    reg fault_prev_q;
    // decoded conditions
    wire supply_ok;
    wire sleep_cond;
    wire deep_cond;
    wire keep_on;
    wire en_fall;

    // pins are asynchronous, two flops before any decision
    pes_sync u_sync_en (.ref_clk(ref_clk), .rst_n(rst_n), .async_in(power_enable_pin),
        .sync_out(en_s));
    pes_sync u_sync_c1 (.ref_clk(ref_clk), .rst_n(rst_n), .async_in(control_input_one),
        .sync_out(c1_s));
    pes_sync u_sync_c2 (.ref_clk(ref_clk), .rst_n(rst_n), .async_in(control_input_two),
        .sync_out(c2_s));
    pes_sync u_sync_hold (.ref_clk(ref_clk), .rst_n(rst_n), .async_in(hold_input),
        .sync_out(hold_s));
    pes_sync u_sync_thr (.ref_clk(ref_clk), .rst_n(rst_n),
        .async_in(supply_above_threshold), .sync_out(thr_s));
    // limit flops reset to out of range, so leaving reset never looks like a good supply
    pes_sync #(.RST_VAL(1'b1)) u_sync_uv (.ref_clk(ref_clk), .rst_n(rst_n),
        .async_in(supply_low_limit), .sync_out(uv_s));
    pes_sync #(.RST_VAL(1'b1)) u_sync_ov (.ref_clk(ref_clk), .rst_n(rst_n),
        .async_in(supply_high_limit), .sync_out(ov_s));
    // threshold decode for the analog monitor
    pes_thr_decode u_thr (.code(mon_cfg_q[`PES_THR_MSB:`PES_THR_LSB]),
        .tenths(threshold_tenths));
    // valid window: above low limit, below high limit
    assign supply_ok = !uv_s && !ov_s;
    // extra input keeps power on when the factory option allows it
    assign keep_on = en_s || (HOLD_INPUT_EN && hold_s);
    assign en_fall = en_prev_q && !keep_on;
    // sleep entry function, combine bit is a parameter so software cannot alter it
    assign sleep_cond = slp_allow_q && (SLEEP_COMBINE ?
        (slp_req_edge_q || (SLEEP_REQ_DEFAULT && (c1_s || c2_s))) :
        ((c1_s && c2_s) && (SLEEP_REQ_DEFAULT || slp_req_edge_q)));
    // deep state only in pin mode here, while enable is low
    assign deep_cond = PIN_MODE && !keep_on && deep_en_q;

    // writes are dropped while in reset, so no setting survives a pass through reset
    // registers; every reset entry restores defaults
    always @(posedge ref_clk) begin
        if (!rst_n || state_q == ST_RESET) begin
            mon_cfg_q <= {5'h00, THR_DEFAULT};
            slp_allow_q <= SLEEP_ALLOW_DEFAULT;
            slp_req_q <= SLEEP_REQ_DEFAULT;
            slp_req_prev_q <= SLEEP_REQ_DEFAULT;
            slp_req_edge_q <= 1'b0;
            deep_en_q <= DEEP_EN_DEFAULT;
        end else begin
            slp_req_prev_q <= slp_req_q;
            // rising edge latched until sleep is taken or the request bit clears; set wins
            if (slp_req_q && !slp_req_prev_q)
                slp_req_edge_q <= 1'b1;
            else if (state_q == ST_SLEEP || !slp_req_q)
                slp_req_edge_q <= 1'b0;
            if (reg_wr && reg_addr == `PES_REG_INPUT_MONITOR_CONFIG)
                mon_cfg_q <= reg_wdata;
            if (reg_wr && reg_addr == `PES_REG_SLEEP_CTRL) begin
                slp_allow_q <= reg_wdata[`PES_SLP_ALLOW_BIT];
                slp_req_q <= reg_wdata[`PES_SLP_REQ_BIT];
                deep_en_q <= reg_wdata[`PES_DEEP_EN_BIT];
            end
        end
    end

    // read back; enable mode visible but has no write path
    always @* begin
        case (reg_addr)
            `PES_REG_INPUT_MONITOR_CONFIG: reg_rdata = mon_cfg_q;
            `PES_REG_SLEEP_CTRL: reg_rdata = {4'h0, PIN_MODE, deep_en_q, slp_req_q,
                slp_allow_q};
            `PES_REG_STATE: reg_rdata = {2'h0, state_q};
            default: reg_rdata = 8'h00;
        endcase
    end

    // a completed start clears the count; only failed attempts add up
    // restart attempt counter on output faults
    always @(posedge ref_clk) begin
        if (!rst_n || state_q == ST_RESET) begin
            restart_q <= 4'h0;
            fault_prev_q <= 1'b0;
            en_prev_q <= 1'b0;
        end else begin
            fault_prev_q <= output_fault;
            en_prev_q <= keep_on;
            if (state_q == ST_ON && regs_started && !output_fault)
                restart_q <= 4'h0;
            else if (output_fault && !fault_prev_q && restart_q != `PES_MAX_RESTARTS)
                restart_q <= restart_q + 4'h1;
        end
    end

    // main state transitions
    always @* begin
        state_d = state_q;
        case (state_q)
            ST_RESET: begin
                // leave as soon as the supply sits in its window
                if (supply_ok)
                    state_d = ST_SEQ;
            end
            ST_SEQ: begin
                if (PIN_MODE && !keep_on && !deep_en_q)
                    state_d = ST_OFF;
                else if (!PIN_MODE && !thr_s)
                    state_d = ST_OFF;
                else if (sleep_cond)
                    state_d = ST_SLEEP;
                else if (deep_cond)
                    state_d = ST_DEEP;
                else if (regs_started)
                    state_d = ST_ON;
            end
            ST_ON: begin
                // a fault drops back to a fresh start attempt
                if (output_fault)
                    state_d = ST_SEQ;
                else if (!PIN_MODE && !thr_s)
                    state_d = ST_OFF;
                else if (sleep_cond)
                    state_d = ST_SLEEP;
                else if (PIN_MODE && en_fall && deep_en_q)
                    state_d = ST_DEEP;
                else if (PIN_MODE && !keep_on)
                    state_d = ST_OFF;
            end
            ST_SLEEP: begin
                // stay while the and-mode inputs still ask for sleep
                if (!sleep_cond && !(slp_allow_q && !SLEEP_COMBINE && c1_s && c2_s))
                    state_d = ST_SEQ;
            end
            ST_DEEP: begin
                // enable high, or software clearing deep enable, wakes
                if (keep_on || !deep_en_q)
                    state_d = ST_SEQ;
            end
            ST_OFF: begin
                // waits for enable, or for the supply to clear threshold
                if ((PIN_MODE && keep_on) || (!PIN_MODE && thr_s))
                    state_d = ST_SEQ;
            end
            default: state_d = ST_RESET;
        endcase
        // supply limits and exhausted restarts override all
        if (!supply_ok || restart_q == `PES_MAX_RESTARTS)
            state_d = ST_RESET;
    end

    // state register
    always @(posedge ref_clk) begin
        if (!rst_n)
            state_q <= ST_RESET;
        else
            state_q <= state_d;
    end
    assign state_onehot = state_q;

    // per-output drive from state; sleep settings apply at once
    genvar gi;
    generate
        for (gi = 0; gi < NUM_OUT; gi = gi + 1) begin : g_out
            wire [1:0] sset = SLEEP_SET_DEFAULT[2*gi+1:2*gi];
            // deep uses alternate only if sleep does not
            wire deep_alt = DEEP_ALT_DEFAULT[gi] && (sset != `PES_SET_ALTERNATE);
            always @(posedge ref_clk) begin
                if (!rst_n) begin
                    out_enable[gi] <= 1'b0;
                    out_use_alt[gi] <= 1'b0;
                end else begin
                    case (state_d)
                        ST_SEQ, ST_ON: begin
                            // delay of off outputs lives in sequencer
                            out_enable[gi] <= 1'b1;
                            out_use_alt[gi] <= 1'b0;
                        end
                        ST_SLEEP: begin
                            out_enable[gi] <= (sset != `PES_SET_OFF);
                            out_use_alt[gi] <= (sset == `PES_SET_ALTERNATE);
                        end
                        ST_DEEP: begin
                            out_enable[gi] <= 1'b1;
                            out_use_alt[gi] <= deep_alt;
                        end
                        default: begin
                            out_enable[gi] <= 1'b0;
                            out_use_alt[gi] <= 1'b0;
                        end
                    endcase
                end
            end
        end
    endgenerate

    // reset output held low in reset and while off
    always @(posedge ref_clk) begin
        if (!rst_n)
            reset_out_n <= 1'b0;
        else
            reset_out_n <= (state_d == ST_ON) || (state_d == ST_SLEEP)
                || (state_d == ST_DEEP);
    end
endmodule // pes_enable_fsm
`default_nettype wire

// ---- include/pes_defines.vh ----
// constants for the power enable state controller
`ifndef PES_DEFINES_VH
`define PES_DEFINES_VH
// register offset and field positions
`define PES_REG_INPUT_MONITOR_CONFIG 8'h0f
`define PES_THR_LSB 0
`define PES_THR_MSB 2
`define PES_INPUT_MONITOR_CONFIG_RST 8'h00
// own control register at an offset of our choosing
`define PES_REG_SLEEP_CTRL 8'h10
`define PES_SLP_ALLOW_BIT 0
`define PES_SLP_REQ_BIT 1
`define PES_DEEP_EN_BIT 2
`define PES_REG_STATE 8'h11
// restart attempts before giving up
`define PES_MAX_RESTARTS 4'h7
// sleep setting encodings per output
`define PES_SET_PRIMARY 2'h0
`define PES_SET_ALTERNATE 2'h1
`define PES_SET_OFF 2'h2
// threshold decode in tenths of a volt
`define PES_THR_000 7'h1e
`define PES_THR_STEP 7'h02
`define PES_THR_110 7'h50
`define PES_THR_111 7'h5a
`endif

// ---- core/pes_sync.v ----
// two flip-flop synchroniser for one bit
`timescale 1ns/1ns
`default_nettype none
module pes_sync #(
    parameter [0:0] RST_VAL = 1'b0
) (
    // clock and reset
    input wire ref_clk,
    input wire rst_n,
    // bit in and out
    input wire async_in,
    output wire sync_out
);
    reg meta_q;
    reg sync_q;
    // first stage feeds only the second
    always @(posedge ref_clk) begin
        if (!rst_n) begin
            meta_q <= RST_VAL; // safe level of the caller, no false edge on release
            sync_q <= RST_VAL;
        end else begin
            meta_q <= async_in;
            sync_q <= meta_q;
        end
    end
    assign sync_out = sync_q;
endmodule // pes_sync
`default_nettype wire

// ---- core/pes_thr_decode.v ----
// threshold code to tenths of a volt
`timescale 1ns/1ns
`default_nettype none
`include "pes_defines.vh"
module pes_thr_decode (
    // code in
    input wire [2:0] code,
    // threshold out, tenths of a volt
    output reg [6:0] tenths
);
    // linear for low codes, two fixed high points
    always @* begin
        case (code)
            3'h6: tenths = `PES_THR_110;
            3'h7: tenths = `PES_THR_111;
            default: tenths = `PES_THR_000 + {code[2:0], 1'b0};
        endcase
    end
endmodule // pes_thr_decode
`default_nettype wire

// ---- tb/pes_proc_model.sv ----
// processor side model driving the enable and control pins
`timescale 1ns/1ns
`default_nettype none
module pes_proc_model (
    // clock
    input wire ref_clk,
    // pins toward the controller
    output logic power_enable_pin,
    output logic control_input_one,
    output logic control_input_two,
    output logic hold_input
);
    logic [3:0] want_q = 4'h0;
    // pins start low, so power arrives with the enable held off
    initial {power_enable_pin, control_input_one, control_input_two, hold_input} = 4'h0;
    // pins move on the falling edge only, never near the sampling edge
    always @(negedge ref_clk) begin
        {power_enable_pin, control_input_one, control_input_two, hold_input} <= want_q;
    end
    // new pattern {enable, one, two, hold}; enable low once running turns off, or enters deep state when deep enable is set
    task automatic drive(input logic [3:0] pins);
        want_q = pins;
    endtask
endmodule // pes_proc_model
`default_nettype wire

// ---- tb/pes_monitor.sv ----
// assertion checker for the power enable state controller
`timescale 1ns/1ns
`default_nettype none
module pes_monitor #(
    parameter NUM_OUT = 6
) (
    // clock and reset
    input wire ref_clk,
    input wire rst_n,
    // watched pins
    input wire control_input_one,
    input wire control_input_two,
    input wire supply_low_limit,
    input wire supply_high_limit,
    input wire output_fault,
    input wire regs_started,
    // register port and state
    input wire [7:0] reg_addr,
    input wire [7:0] reg_rdata,
    input wire [NUM_OUT-1:0] out_enable,
    input wire reset_out_n,
    input wire [6:0] threshold_tenths,
    input wire [5:0] state_onehot
);
    reg fault_q;
    reg [2:0] fault_cnt_q;
    wire [2:0] fault_cnt_d;
    // fault edges add up outside reset, the way restart attempts do
    assign fault_cnt_d = (state_onehot == 6'h01) ? 3'h0
        : fault_cnt_q + {2'h0, output_fault & ~fault_q};
    always @(posedge ref_clk) begin
        fault_q <= rst_n & output_fault;
        fault_cnt_q <= rst_n ? fault_cnt_d : 3'h0;
    end
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!rst_n);
    a_reset_all_off: assert property (
        state_onehot == 6'h01 |-> out_enable == '0 && !reset_out_n)
        else $error("outputs live in reset");
    a_reset_cfg_default: assert property (
        state_onehot == 6'h01 ##1 state_onehot == 6'h01 && reg_addr == 8'h0f |-> reg_rdata == 8'h00)
        else $error("config kept through reset");
    a_thr_decode: assert property (
        reg_addr == 8'h0f |-> threshold_tenths == ((reg_rdata[2] & reg_rdata[1])
        ? (reg_rdata[0] ? 7'h5a : 7'h50) : 7'h1e + {3'h0, reg_rdata[2:0], 1'b0}))
        else $error("threshold decode wrong");
    a_limit_to_reset: assert property (
        (supply_low_limit || supply_high_limit) [*3] |-> ##[0:4] state_onehot == 6'h01)
        else $error("supply out of range without reset");
    a_fault_to_reset: assert property (
        output_fault && !fault_q && fault_cnt_q == 3'h6 |-> ##[0:4] state_onehot == 6'h01)
        else $error("seventh fault did not reset");
    a_seq_brief: assert property (
        state_onehot == 6'h02 && regs_started |-> ##[1:3] state_onehot != 6'h02)
        else $error("sequence start not left");
    a_sleep_and: assert property (
        $rose(state_onehot == 6'h08) |-> $past(control_input_one, 3) && $past(control_input_two, 3))
        else $error("sleep without both inputs");
    a_sleep_outputs: assert property (
        state_onehot == 6'h08 |-> out_enable == '0)
        else $error("sleep setting not applied");
    c_sleep: cover property (state_onehot == 6'h08);
    c_deep: cover property (state_onehot == 6'h10);
    c_fault_reset: cover property (fault_cnt_q == 3'h6 ##[1:4] state_onehot == 6'h01);
endmodule // pes_monitor
bind pes_enable_fsm pes_monitor #(.NUM_OUT(NUM_OUT)) u_monitor (
    .ref_clk(ref_clk), .rst_n(rst_n), .control_input_one(control_input_one),
    .control_input_two(control_input_two), .supply_low_limit(supply_low_limit),
    .supply_high_limit(supply_high_limit), .output_fault(output_fault),
    .regs_started(regs_started), .reg_addr(reg_addr), .reg_rdata(reg_rdata),
    .out_enable(out_enable), .reset_out_n(reset_out_n),
    .threshold_tenths(threshold_tenths), .state_onehot(state_onehot));
`default_nettype wire

// ---- tb/tb.sv ----
// self-checking bench for the power enable state controller
`timescale 1ns/1ns
`default_nettype none
module tb;
    logic ref_clk = 1'b0;
    logic rst_n = 1'b0;
    logic supply_above_threshold = 1'b1;
    logic supply_low_limit = 1'b1;
    logic supply_high_limit = 1'b0;
    logic output_fault = 1'b0;
    logic regs_started = 1'b1;
    logic reg_wr = 1'b0;
    logic [7:0] reg_addr = 8'h00;
    logic [7:0] reg_wdata = 8'h00;
    wire power_enable_pin, control_input_one, control_input_two, hold_input, reset_out_n;
    wire [7:0] reg_rdata;
    wire [5:0] out_enable, out_use_alt, state_onehot;
    wire [6:0] threshold_tenths;
    int mismatches = 0;
    int checked = 0;
    logic [7:0] thr_tab [8] = '{8'h1e, 8'h20, 8'h22, 8'h24, 8'h26, 8'h28, 8'h50, 8'h5a};
    pes_proc_model u_proc (.ref_clk(ref_clk), .power_enable_pin(power_enable_pin),
        .control_input_one(control_input_one), .control_input_two(control_input_two),
        .hold_input(hold_input));
    pes_enable_fsm #(.HOLD_INPUT_EN(1'b1), .DEEP_ALT_DEFAULT(6'h0c)) u_dut (.ref_clk(ref_clk),
        .rst_n(rst_n), .power_enable_pin(power_enable_pin),
        .control_input_one(control_input_one), .control_input_two(control_input_two),
        .hold_input(hold_input), .supply_above_threshold(supply_above_threshold),
        .supply_low_limit(supply_low_limit), .supply_high_limit(supply_high_limit),
        .output_fault(output_fault), .regs_started(regs_started), .reg_wr(reg_wr),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
        .out_enable(out_enable), .out_use_alt(out_use_alt), .reset_out_n(reset_out_n),
        .threshold_tenths(threshold_tenths), .state_onehot(state_onehot));
    // 50 MHz clock
    always #10 ref_clk = ~ref_clk;
    task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string what);
        checked++;
        if (got !== exp) begin
            mismatches++;
            $display("mismatch at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask
    // one-cycle write strobe, released a full cycle later
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge ref_clk);
        reg_addr = a;
        reg_wdata = d;
        reg_wr = 1'b1;
        @(negedge ref_clk);
        reg_wr = 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] exp, input string what);
        @(negedge ref_clk);
        reg_addr = a;
        #5 chk(reg_rdata, exp, what);
    endtask
    // bounded poll; a one-cycle state is still seen at its falling edge
    task automatic wait_state(input logic [5:0] exp, input int n);
        for (int i = 0; i < n && state_onehot !== exp; i++) @(negedge ref_clk);
        chk({2'h0, state_onehot}, {2'h0, exp}, "state");
    endtask
    task automatic t_reset();
        wr(8'h0f, 8'h05);
        rd(8'h0f, 8'h00, "cfg write in reset");
        chk({2'h0, out_enable}, 8'h00, "outputs in reset");
        chk({7'h0, reset_out_n}, 8'h00, "reset out");
        supply_low_limit = 1'b0;
        wait_state(6'h02, 10);
    endtask
    task automatic t_pin();
        repeat (8) @(negedge ref_clk);
        chk({2'h0, out_enable}, 8'h00, "enable low");
        regs_started = 1'b0;
        u_proc.drive(4'h8);
        wait_state(6'h02, 10);
        repeat (4) @(negedge ref_clk);
        chk({2'h0, state_onehot}, 8'h02, "start pending");
        regs_started = 1'b1;
        wait_state(6'h04, 10);
        chk({7'h0, reset_out_n}, 8'h01, "reset out");
        supply_above_threshold = 1'b0;
        u_proc.drive(4'h1);
        repeat (8) @(negedge ref_clk);
        chk({2'h0, state_onehot}, 8'h04, "hold input");
        u_proc.drive(4'h8);
        supply_above_threshold = 1'b1;
    endtask
    task automatic t_regs();
        for (int i = 0; i < 8; i++) begin
            wr(8'h0f, {5'h00, i[2:0]});
            chk({1'h0, threshold_tenths}, thr_tab[i], "threshold");
        end
        wr(8'h10, 8'h00);
        rd(8'h10, 8'h08, "mode bit");
        wr(8'h20, 8'hff);
        rd(8'h20, 8'h00, "unmapped");
    endtask
    task automatic t_sleep();
        u_proc.drive(4'he);
        repeat (8) @(negedge ref_clk);
        chk({2'h0, state_onehot}, 8'h04, "allow off");
        u_proc.drive(4'hc);
        repeat (4) @(negedge ref_clk);
        wr(8'h10, 8'h03);
        repeat (8) @(negedge ref_clk);
        chk({2'h0, state_onehot}, 8'h04, "one input");
        u_proc.drive(4'he);
        wait_state(6'h08, 10);
        chk({2'h0, out_enable}, 8'h00, "sleep outputs");
        chk({2'h0, out_use_alt}, 8'h00, "sleep alternate");
        u_proc.drive(4'h8);
        wait_state(6'h02, 10);
        wait_state(6'h04, 10);
        u_proc.drive(4'he);
        repeat (8) @(negedge ref_clk);
        chk({2'h0, state_onehot}, 8'h04, "stale request");
        wr(8'h10, 8'h00);
        u_proc.drive(4'h8);
    endtask
    task automatic t_deep();
        wr(8'h10, 8'h04);
        u_proc.drive(4'h0);
        wait_state(6'h10, 10);
        chk({2'h0, out_enable}, 8'h3f, "deep outputs");
        chk({2'h0, out_use_alt}, 8'h0c, "deep alternate");
        u_proc.drive(4'h8);
        wait_state(6'h04, 12);
        wr(8'h10, 8'h00);
    endtask
    task automatic t_faults();
        wr(8'h0f, 8'h05);
        wait_state(6'h04, 12);
        // restarts never complete, so every fault is a failed attempt
        regs_started = 1'b0;
        for (int i = 0; i < 7; i++) begin
            if (i == 6) chk({2'h0, state_onehot}, 8'h02, "six failed starts");
            output_fault = 1'b1;
            @(negedge ref_clk);
            output_fault = 1'b0;
            @(negedge ref_clk);
        end
        wait_state(6'h01, 10);
        regs_started = 1'b1;
        wait_state(6'h04, 20);
        rd(8'h0f, 8'h00, "cfg after fault reset");
    endtask
    task automatic t_supply();
        wr(8'h0f, 8'h03);
        supply_high_limit = 1'b1;
        wait_state(6'h01, 10);
        chk({2'h0, out_enable}, 8'h00, "outputs over limit");
        supply_high_limit = 1'b0;
        wait_state(6'h04, 20);
        rd(8'h0f, 8'h00, "cfg after supply reset");
    endtask
    task automatic tally_and_finish();
        $display("checked %0d mismatches %0d", checked, mismatches);
        if (mismatches == 0 && checked > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask
    // main sequence after ten reset cycles
    initial begin
        repeat (10) @(negedge ref_clk);
        rst_n = 1'b1;
        t_reset();
        t_pin();
        t_regs();
        t_sleep();
        t_deep();
        t_faults();
        t_supply();
        tally_and_finish();
    end
    // watchdog well past the roughly 150 cycles the tests need
    initial begin
        #100000;
        mismatches++;
        tally_and_finish();
    end
endmodule // tb
`default_nettype wire
